// ### rtl/lbm_cfg.svh
`ifndef LBM_CFG_SVH
`define LBM_CFG_SVH

// Register byte addresses.
`define LBM_OFS_LADDER   8'h00
`define LBM_OFS_CONTROL  8'h04
`define LBM_OFS_BIASREF  8'h08
`define LBM_OFS_CONTRAST 8'h0C
`define LBM_OFS_STATUS   8'h10
`define LBM_OFS_SEGEN    8'h14
`define LBM_OFS_PIXEL0   8'h20
`define LBM_OFS_PIXEL3   8'h2C

// Ladder power control fields.
`define LBM_LAD_ATIME_LSB 0
`define LBM_LAD_ATIME_MSB 2
`define LBM_LAD_BPWR_LSB  4
`define LBM_LAD_BPWR_MSB  5
`define LBM_LAD_APWR_LSB  6
`define LBM_LAD_APWR_MSB  7
`define LBM_LAD_MASK      8'hF7

// Control fields.
`define LBM_CTL_MUX_LSB   0
`define LBM_CTL_MUX_MSB   1
`define LBM_CTL_WFT_BIT   2
`define LBM_CTL_EN_BIT    3
`define LBM_CTL_MASK      8'h0F

// Bias reference fields.
`define LBM_REF_EN_BIT    0
`define LBM_REF_FVR_BIT   1
`define LBM_REF_IDLE_BIT  2
`define LBM_REF_EXT_LSB   3
`define LBM_REF_EXT_MSB   5
`define LBM_REF_MASK      8'h3F

// Contrast field.
`define LBM_CST_MASK      8'h07
`define LBM_CST_LSB       0
`define LBM_CST_MSB       2

// Status fields.
`define LBM_ST_ACT_BIT    0
`define LBM_ST_PHB_BIT    1
`define LBM_ST_REF_BIT    2
`define LBM_ST_BUF_BIT    3

// Reset values.
`define LBM_RST_BYTE      8'h00
`define LBM_RST_WORD      32'h0000_0000

// Ladder interval lengths in 32 kHz periods.
`define LBM_INTV_TYPE_A   6'h10
`define LBM_INTV_TYPE_B   6'h20
`define LBM_CNT_ONE       6'h01
`define LBM_CNT_ZERO      6'h00

// Number of commons.
`define LBM_NUM_COM       4

`endif

// ### rtl/lbm_ctrl.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lbm_cfg.svh"

module lbm_ctrl
  import lbm_pkg::*;
#(
  parameter int SEG_N = 32
)
(
  // Clock, reset and enable.
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // APB slave.
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output var  logic                  pready_out,
  output var  logic [31:0]           prdata_out,
  output var  logic                  pslverr_out,
  // Slow clock pin and port direction bits.
  input  wire logic                  clk32k_in,
  input  wire logic [3:0]            com_dir_in,
  input  wire logic [SEG_N-1:0]      seg_dir_in,
  // Bias and reference controls.
  output var  logic [1:0]            ladder_power_out,
  output var  logic                  ladder_phase_b_out,
  output var  logic [2:0]            contrast_tap_out,
  output var  logic                  contrast_on_out,
  output var  logic                  int_ref_on_out,
  output var  logic                  ref_src_fvr_out,
  output var  logic                  ref_buffer_on_out,
  output var  logic                  fvr_request_out,
  output var  logic [2:0]            ext_bias_en_out,
  output var  logic                  module_active_out,
  // Pin function selection.
  output var  logic [3:0]            com_active_out,
  output var  logic [3:0]            com_oe_out,
  output var  logic [1:0]            common_mux_out,
  output var  logic [SEG_N-1:0]      seg_lcd_out,
  output var  logic [SEG_N-1:0]      seg_oe_out,
  output var  logic [4*SEG_N-1:0]    pixel_data_out
);

  // One word of pixel data per common keeps the bus decode trivial, so a common holds at most 32 segments.
  generate
    if (SEG_N < 1 || SEG_N > 32)
    begin : g_seg_n_check
      $error("SEG_N must lie between 1 and 32");
    end
  endgenerate

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Registers.
  logic [7:0]       ladder_q;
  logic [7:0]       control_q;
  logic [7:0]       biasref_q;
  logic [7:0]       contrast_q;
  logic [SEG_N-1:0] segen_q;
  logic [SEG_N-1:0] pix_q [`LBM_NUM_COM];
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             s1_q;
  logic             s2_q;
  logic             s3_q;
  logic [5:0]       cnt_q;
  logic [5:0]       cnt_d;
  lbm_phase_e       phase_q;
  lbm_phase_e       phase_d;

  // Bus decode.
  wire        acc       = psel_in & penable_in;
  wire        done      = acc & pready_q;
  wire        wr        = done & pwrite_in;
  wire        a_ladder  = hit(paddr_in, `LBM_OFS_LADDER);
  wire        a_control = hit(paddr_in, `LBM_OFS_CONTROL);
  wire        a_biasref = hit(paddr_in, `LBM_OFS_BIASREF);
  wire        a_contr   = hit(paddr_in, `LBM_OFS_CONTRAST);
  wire        a_status  = hit(paddr_in, `LBM_OFS_STATUS);
  wire        a_segen   = hit(paddr_in, `LBM_OFS_SEGEN);
  wire        a_pixel   = (paddr_in >= `LBM_OFS_PIXEL0) && (paddr_in <= `LBM_OFS_PIXEL3) && (paddr_in[1:0] == 2'b00);
  wire [1:0]  pix_idx   = paddr_in[3:2];
  wire        mapped    = a_ladder | a_control | a_biasref | a_contr | a_status | a_segen | a_pixel;

  // Field views.
  wire [2:0]  atime     = ladder_q[`LBM_LAD_ATIME_MSB:`LBM_LAD_ATIME_LSB];
  wire [1:0]  bpwr      = ladder_q[`LBM_LAD_BPWR_MSB:`LBM_LAD_BPWR_LSB];
  wire [1:0]  apwr      = ladder_q[`LBM_LAD_APWR_MSB:`LBM_LAD_APWR_LSB];
  wire [1:0]  mux       = control_q[`LBM_CTL_MUX_MSB:`LBM_CTL_MUX_LSB];
  wire        waveform_type_sel       = control_q[`LBM_CTL_WFT_BIT];
  wire        active    = control_q[`LBM_CTL_EN_BIT];
  wire        ref_en    = biasref_q[`LBM_REF_EN_BIT];
  wire        fvr_sel   = biasref_q[`LBM_REF_FVR_BIT];
  wire        idle_en   = biasref_q[`LBM_REF_IDLE_BIT];

  // Ladder sequencing.
  wire        tick      = s2_q & ~s3_q;
  wire [5:0]  intv      = waveform_type_sel ? `LBM_INTV_TYPE_B : `LBM_INTV_TYPE_A;
  wire        last      = (cnt_q == (intv - `LBM_CNT_ONE));
  wire        in_a      = ({3'b000, atime} > cnt_d);

  always_comb
  begin
    cnt_d = cnt_q;
    if (!active)
    begin
      cnt_d = `LBM_CNT_ZERO;
    end
    else if (tick)
    begin
      cnt_d = last ? `LBM_CNT_ZERO : (cnt_q + `LBM_CNT_ONE);
    end
  end

  always_comb
  begin
    case (phase_q)
      LBM_PH_A:
      begin
        phase_d = in_a ? LBM_PH_A : LBM_PH_B;
      end
      LBM_PH_B:
      begin
        phase_d = in_a ? LBM_PH_A : LBM_PH_B;
      end
      default:
      begin
        phase_d = LBM_PH_B;
      end
    endcase
  end

  // Derived outputs.
  wire        ph_b      = (phase_d == LBM_PH_B);
  wire [1:0]  lad_pwr_d = !active ? 2'b00 : (ph_b ? bpwr : apwr);
  wire        ref_on_d  = active & ref_en;
  wire        cst_on_d  = active & ref_en;
  wire        buf_on_d  = ref_on_d & fvr_sel & ~(idle_en & ph_b);
  wire        fvr_req_d = ref_on_d & fvr_sel;
  wire [3:0]  com_act_d;
  wire [3:0]  com_oe_d;
  wire [SEG_N-1:0] seg_oe_d = segen_q | ~seg_dir_in;

  genvar gi;
  generate
    for (gi = 0; gi < `LBM_NUM_COM; gi++)
    begin : g_com
      assign com_act_d[gi] = active & (2'(gi) <= mux);
      assign com_oe_d[gi]  = com_act_d[gi] | ~com_dir_in[gi];
    end
  endgenerate

  wire [31:0] status_w  = {28'h0000000, buf_on_d, ref_on_d, ph_b, active};

  logic [31:0] rdata_d;
  always_comb
  begin
    rdata_d = `LBM_RST_WORD;
    if (a_ladder)  rdata_d = {24'h000000, ladder_q};
    if (a_control) rdata_d = {24'h000000, control_q};
    if (a_biasref) rdata_d = {24'h000000, biasref_q};
    if (a_contr)   rdata_d = {24'h000000, contrast_q};
    if (a_status)  rdata_d = status_w;
    if (a_segen)   rdata_d = 32'(segen_q);
    if (a_pixel)   rdata_d = 32'(pix_q[pix_idx]);
  end

  // Bus answer: one wait state, so every answer leaves a flip-flop.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= `LBM_RST_WORD;
      pslverr_q <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~pwrite_in) ? rdata_d : `LBM_RST_WORD;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end

  // Software registers.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ladder_q   <= `LBM_RST_BYTE;
      control_q  <= `LBM_RST_BYTE;
      biasref_q  <= `LBM_RST_BYTE;
      contrast_q <= `LBM_RST_BYTE;
      segen_q    <= '0;
    end
    else if (ce_in && wr)
    begin
      if (a_ladder)  ladder_q   <= pwdata_in[7:0] & `LBM_LAD_MASK;
      if (a_control) control_q  <= pwdata_in[7:0] & `LBM_CTL_MASK;
      if (a_biasref) biasref_q  <= pwdata_in[7:0] & `LBM_REF_MASK;
      if (a_contr)   contrast_q <= pwdata_in[7:0] & `LBM_CST_MASK;
      if (a_segen)   segen_q    <= pwdata_in[SEG_N-1:0];
    end
  end

  // Pixel memory: one bit per common and segment pair.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < `LBM_NUM_COM; i++)
      begin
        pix_q[i] <= '0;
      end
    end
    else if (ce_in && wr && a_pixel)
    begin
      pix_q[pix_idx] <= pwdata_in[SEG_N-1:0];
    end
  end

  // Slow clock synchroniser: the second and third stages feed logic, second high with third low marking its rising edge.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      s1_q    <= clk32k_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
    end
  end

  // Ladder counter and phase.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q   <= `LBM_CNT_ZERO;
      phase_q <= LBM_PH_B;
    end
    else if (ce_in)
    begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  // Registered bias and reference outputs.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ladder_power_out   <= 2'b00;
      ladder_phase_b_out <= 1'b1;
      contrast_tap_out   <= 3'b000;
      contrast_on_out    <= 1'b0;
      int_ref_on_out     <= 1'b0;
      ref_src_fvr_out    <= 1'b0;
      ref_buffer_on_out  <= 1'b0;
      fvr_request_out    <= 1'b0;
      ext_bias_en_out    <= 3'b000;
      module_active_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      ladder_power_out   <= lad_pwr_d;
      ladder_phase_b_out <= ph_b;
      contrast_tap_out   <= contrast_q[`LBM_CST_MSB:`LBM_CST_LSB];
      contrast_on_out    <= cst_on_d;
      int_ref_on_out     <= ref_on_d;
      ref_src_fvr_out    <= fvr_sel;
      ref_buffer_on_out  <= buf_on_d;
      fvr_request_out    <= fvr_req_d;
      ext_bias_en_out    <= biasref_q[`LBM_REF_EXT_MSB:`LBM_REF_EXT_LSB];
      module_active_out  <= active;
    end
  end

  // Registered pin function outputs.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      com_active_out     <= 4'h0;
      com_oe_out         <= 4'h0;
      common_mux_out     <= 2'b00;
      seg_lcd_out        <= '0;
      seg_oe_out         <= '0;
    end
    else if (ce_in)
    begin
      com_active_out     <= com_act_d;
      com_oe_out         <= com_oe_d;
      common_mux_out     <= mux;
      seg_lcd_out        <= segen_q;
      seg_oe_out         <= seg_oe_d;
    end
  end

  // Registered pixel image.
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pixel_data_out     <= '0;
    end
    else if (ce_in)
    begin
      pixel_data_out     <= {pix_q[3], pix_q[2], pix_q[1], pix_q[0]};
    end
  end

  assign pready_out  = pready_q;
  assign prdata_out  = prdata_q;
  assign pslverr_out = pslverr_q;

endmodule

`default_nettype wire

// ### rtl/lbm_pkg.sv
package lbm_pkg;

  typedef enum logic {
    LBM_PH_A,
    LBM_PH_B
  } lbm_phase_e;

  typedef logic [1:0] lbm_pwr_t;

endpackage

// ### verification/lbm_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lbm_ctrl_assertions
#(
  parameter int SEG_N = 32
)
(
  input wire logic             clock_in,
  input wire logic             rstn_in,
  input wire logic             ce_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic [3:0]       com_dir_in,
  input wire logic [SEG_N-1:0] seg_dir_in,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  input wire logic [1:0]       ladder_power_out,
  input wire logic             contrast_on_out,
  input wire logic             int_ref_on_out,
  input wire logic             ref_src_fvr_out,
  input wire logic             fvr_request_out,
  input wire logic             module_active_out,
  input wire logic [3:0]       com_active_out,
  input wire logic [3:0]       com_oe_out,
  input wire logic [1:0]       common_mux_out,
  input wire logic [SEG_N-1:0] seg_lcd_out,
  input wire logic [SEG_N-1:0] seg_oe_out
);
  // Checks wait three edges after reset so that past values never come from inside reset.
  logic [1:0] arm_q;
  wire        armed   = (arm_q == 2'h3);
  wire  [3:0] com_exp = {common_mux_out == 2'h3, common_mux_out[1], common_mux_out != 2'h0, 1'b1};
  always_ff @(posedge clock_in or negedge rstn_in)
    if (!rstn_in)
      arm_q <= 2'h0;
    else if (!armed)
      arm_q <= arm_q + 2'h1;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in || !armed);
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_access; psel_in && penable_in; endsequence
  AST_APB_LAT: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("ready not on second access cycle");
  AST_RDY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
  AST_ERR_RDY: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  AST_COM_MUX: assert property (module_active_out |-> com_active_out == com_exp)
    else $error("active commons wrong");
  AST_COM_OE: assert property ($past(ce_in) |-> com_oe_out == (com_active_out | ~$past(com_dir_in)))
    else $error("common enable wrong");
  AST_SEG_OE: assert property ($past(ce_in) |-> seg_oe_out == (seg_lcd_out | ~$past(seg_dir_in)))
    else $error("segment enable wrong");
  AST_CST_OFF: assert property (!module_active_out |-> !contrast_on_out) else $error("contrast on");
  AST_REF_OFF: assert property (!module_active_out |-> !int_ref_on_out) else $error("reference on");
  AST_FVR_REQ: assert property (int_ref_on_out && ref_src_fvr_out |-> fvr_request_out)
    else $error("no fixed reference request");
  AST_LAD_OFF: assert property (!module_active_out |-> ladder_power_out == 2'h0) else $error("ladder powered");
endmodule
bind lbm_ctrl lbm_ctrl_assertions #(.SEG_N(SEG_N)) u_chk (.clock_in, .rstn_in, .ce_in, .psel_in, .penable_in,
  .com_dir_in, .seg_dir_in, .pready_out, .pslverr_out, .ladder_power_out, .contrast_on_out, .int_ref_on_out,
  .ref_src_fvr_out, .fvr_request_out, .module_active_out, .com_active_out, .com_oe_out, .common_mux_out,
  .seg_lcd_out, .seg_oe_out);
`default_nettype wire

// ### verification/lbm_glass.sv
`timescale 1ns/1ps
`default_nettype none
module lbm_glass
#(
  parameter int SEG_N = 32
)
(
  input  wire logic [3:0]         com_active_in,
  input  wire logic [SEG_N-1:0]   seg_lcd_in,
  input  wire logic [4*SEG_N-1:0] pixel_in,
  output logic      [4*SEG_N-1:0] lit_out
);
  // A pixel lights only where its common and its segment are both driven.
  for (genvar c = 0; c < 4; c++)
  begin : g_com
    assign lit_out[c*SEG_N +: SEG_N] = pixel_in[c*SEG_N +: SEG_N] & seg_lcd_in & {SEG_N{com_active_in[c]}};
  end
endmodule
`default_nettype wire

// ### verification/lcd_bias_mux_segment_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbm_cfg.svh"
module lcd_bias_mux_segment_control_tb;
  logic        clock_in, rstn_in, psel, pen, pwr, clk32k, e, ce, pa;
  logic [7:0]  paddr;
  logic [31:0] pwdata, r, v, s, seg_dir;
  logic [31:0] pix [4];
  logic [3:0]  com_dir;
  logic [2:0]  at, x;
  logic [1:0]  ap, bp;
  int          err_total, n_tests, cyc, i, j, k, cnt;
  wire         pready, pslverr, phb, con, iref, rsrc, rbuf, freq, mact;
  wire [31:0]  prdata, slcd, soe;
  wire [1:0]   lpwr, cmux;
  wire [2:0]   ctap, ext;
  wire [3:0]   cact, coe;
  wire [127:0] pixo, lit;
  lbm_ctrl uut (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .clk32k_in(clk32k), .com_dir_in(com_dir), .seg_dir_in(seg_dir),
    .ladder_power_out(lpwr), .ladder_phase_b_out(phb), .contrast_tap_out(ctap), .contrast_on_out(con),
    .int_ref_on_out(iref), .ref_src_fvr_out(rsrc), .ref_buffer_on_out(rbuf), .fvr_request_out(freq),
    .ext_bias_en_out(ext), .module_active_out(mact), .com_active_out(cact), .com_oe_out(coe),
    .common_mux_out(cmux), .seg_lcd_out(slcd), .seg_oe_out(soe), .pixel_data_out(pixo));
  lbm_glass glass (.com_active_in(cact), .seg_lcd_in(slcd), .pixel_in(pixo), .lit_out(lit));
  always #12.5 clock_in = ~clock_in;
  function automatic logic [31:0] f_mask(int n);
    return (n == 0) ? 32'hF7 : (n == 1) ? 32'h0F : (n == 2) ? 32'h3F : (n == 3) ? 32'h07 : 32'hFFFFFFFF;
  endfunction
  function automatic logic [3:0] f_com(int m);
    return 4'((1 << (m + 1)) - 1);
  endfunction
  // Ladder is in A mode while the interval count, one ahead of the slow pulse index, is below the A time.
  function automatic logic f_ina(int j, int n, logic [2:0] t);
    return ((j + 1) % n) < t;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the whole request until ready is sampled high, then releases and lets one edge pass.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clock_in);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic slow();
    clk32k <= 1'b1;
    repeat (5) @(posedge clock_in);
    clk32k <= 1'b0;
    repeat (5) @(posedge clock_in);
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  initial
  begin
    clock_in = 1'b0;
    rstn_in = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    clk32k = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    com_dir = 4'hF;
    seg_dir = 32'hFFFFFFFF;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(86416));
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    for (i = 0; i < 12; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk_rd(r, (i == 4) ? 32'h2 : 32'h0);
      chk_rd({31'h0, e}, {31'h0, i == 6 || i == 7});
    end
    for (i = 0; i < 12; i++)
      if (i != 4 && i != 6 && i != 7)
      begin
        v = $urandom;
        wr(8'(i * 4), v);
        apb(1'b0, 8'(i * 4), 32'h0);
        chk_rd(r, v & f_mask(i));
        if (i > 7)
          pix[i - 8] = v;
      end
    chk_pin(pixo, {pix[3], pix[2], pix[1], pix[0]});
    com_dir <= 4'($urandom);
    seg_dir <= $urandom;
    wr(`LBM_OFS_SEGEN, 32'hFFFFFFFF);
    for (i = 0; i < 4; i++)
    begin
      wr(`LBM_OFS_CONTROL, 32'h8 | i);
      repeat (2) @(posedge clock_in);
      chk_pin(cact, f_com(i));
      chk_pin(coe, {f_com(i) | ~com_dir});
      chk_pin(soe, 32'hFFFFFFFF);
      chk_pin({mact, cmux}, {1'b1, 2'(i)});
      v = 32'(f_com(i));
      chk_pin(lit, {v[3] ? pix[3] : 32'h0, v[2] ? pix[2] : 32'h0, v[1] ? pix[1] : 32'h0, pix[0]});
    end
    s = $urandom;
    wr(`LBM_OFS_SEGEN, s);
    repeat (2) @(posedge clock_in);
    chk_pin(slcd, s);
    chk_pin(soe, {s | ~seg_dir});
    ce <= 1'b0;
    seg_dir <= ~seg_dir;
    repeat (3) @(posedge clock_in);
    chk_pin(soe, {s | seg_dir});
    ce <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk_pin(soe, {s | ~seg_dir});
    for (k = 0; k < 8; k++)
    begin
      at = (k < 2) ? 3'h0 : (k < 4) ? 3'h2 : (k < 6) ? 3'h6 : 3'h7;
      ap = 2'($urandom);
      bp = 2'($urandom);
      x = 3'($urandom);
      wr(`LBM_OFS_CONTROL, 32'h0);
      wr(`LBM_OFS_LADDER, {24'h0, ap, bp, 1'b0, at});
      wr(`LBM_OFS_BIASREF, {26'h0, x, 3'h0});
      wr(`LBM_OFS_CONTROL, {29'h1, k[0], 2'h0});
      cnt = 0;
      for (j = 0; j < (k[0] ? 64 : 32); j++)
      begin
        slow();
        pa = f_ina(j, k[0] ? 32 : 16, at);
        cnt += (phb === 1'b0);
        chk_pin({phb, lpwr}, {!pa, pa ? ap : bp});
      end
      chk_pin(cnt, 2 * at);
      chk_pin(ext, x);
    end
    wr(`LBM_OFS_LADDER, 32'h0);
    wr(`LBM_OFS_CONTRAST, 32'h7);
    for (i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 32'h7 : (i == 1) ? 32'h3 : (i == 2) ? 32'h1 : 32'h0;
      wr(`LBM_OFS_BIASREF, v);
      repeat (2) @(posedge clock_in);
      chk_pin({con, iref, rsrc}, {v[0], v[0], v[1]});
      chk_pin(rbuf, v[0] & v[1] & !v[2]);
      chk_pin(freq, v[0] & v[1]);
    end
    chk_pin(ctap, 3'h7);
    wr(`LBM_OFS_BIASREF, 32'h3);
    wr(`LBM_OFS_CONTROL, 32'h0);
    repeat (2) @(posedge clock_in);
    chk_pin({mact, con, iref}, 3'h0);
    final_report();
  end
endmodule
`default_nettype wire
